// >>> verilog/vid_pkg.sv
package vid_pkg;
  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [7:0] IX_MAKER = 8'h00;
  localparam logic [7:0] IX_PRODUCT = 8'h01;
  localparam logic [7:0] IX_SIREV = 8'h02;
  localparam logic [7:0] IX_PROTO = 8'h05;
  localparam logic [7:0] IX_FEATURE = 8'h06;
  localparam logic [7:0] IX_STAT1 = 8'h10;
  localparam logic [7:0] IX_STAT2 = 8'h11;
  localparam logic [7:0] IX_TZONE = 8'h12;
  localparam logic [7:0] IX_PREVGET = 8'h14;
  localparam logic [7:0] IX_IOUT = 8'h15;
  localparam logic [7:0] IX_VOUT = 8'h16;
  localparam logic [7:0] IX_HEAT = 8'h17;
  localparam logic [7:0] IX_POUT = 8'h18;
  localparam logic [7:0] IX_VIN = 8'h1a;
  localparam logic [7:0] IX_PIN = 8'h1b;
  localparam logic [7:0] IX_SNAP = 8'h1c;
  localparam logic [7:0] IX_CCL = 8'h1f;
  localparam logic [7:0] IX_PLATLIM = 8'h21;
  localparam logic [7:0] IX_HEATMAX = 8'h22;
  localparam logic [7:0] IX_QRATE = 8'h24;
  localparam logic [7:0] IX_GRATE = 8'h25;
  localparam logic [7:0] IX_BOOT = 8'h26;
  localparam logic [7:0] IX_GDIV = 8'h2a;
  localparam logic [7:0] IX_DEEPLAT = 8'h2b;
  localparam logic [7:0] IX_LIGHTLAT = 8'h2c;
  localparam logic [7:0] IX_RDYLAT = 8'h2d;
  localparam logic [7:0] IX_CEIL = 8'h30;
  localparam logic [7:0] IX_CURCODE = 8'h31;
  localparam logic [7:0] IX_PSTATE = 8'h32;
  localparam logic [7:0] IX_MARGIN = 8'h33;
  localparam logic [7:0] IX_MULTI = 8'h34;
  localparam logic [7:0] IX_WPTR = 8'h35;
  localparam logic [7:0] IX_DBCCLR = 8'h49;
  localparam logic [7:0] IX_CRIT = 8'h4a;
  localparam logic [7:0] IX_W2LVL = 8'h4b;
  localparam logic [7:0] IX_W1LVL = 8'h4c;
  localparam logic [7:0] IX_W2CNT = 8'h4d;
  localparam logic [7:0] IX_W1CNT = 8'h4e;
  localparam logic [7:0] IX_DBCSET = 8'h4f;
  localparam logic [7:0] IX_ICCADD = 8'h50;
  localparam logic [7:0] IX_CCLCNT = 8'h5c;
  // ----------------------------------------
  // fixed values and reset values
  // ----------------------------------------
  localparam logic [7:0] PROTO_VAL = 8'h0e;
  localparam logic [7:0] FEATURE_VAL = 8'hd7;
  localparam logic [7:0] HEATMAX_RST = 8'h64;
  localparam logic [7:0] GDIV_RST = 8'h02;
  localparam logic [7:0] DEEPLAT_VAL = 8'h7b;
  localparam logic [7:0] LIGHTLAT_VAL = 8'hca - 8'h75;
  localparam logic [7:0] RDYLAT_VAL = 8'hca;
  localparam logic [7:0] CEIL_RST = 8'hff;
  localparam logic [7:0] WPTR_RST = 8'h35;
  localparam logic [7:0] CODE_MAX = 8'hff;
  // ----------------------------------------
  // link frame and commands
  // ----------------------------------------
  localparam int RX_BITS = 22;
  localparam int TX_BITS = 11;
  localparam logic [4:0] CMD_QUICK = 5'h01;
  localparam logic [4:0] CMD_GENTLE = 5'h02;
  localparam logic [4:0] CMD_UNRAMP = 5'h03;
  localparam logic [4:0] CMD_GET = 5'h07;
  localparam logic [4:0] CMD_SETREG = 5'h08;
  localparam logic [1:0] ACK_OK = 2'h2;
  localparam logic [1:0] ACK_REJ = 2'h3;
  localparam logic [1:0] ACK_BAD = 2'h1;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS * 1000 / CLK_PERIOD_PS;
  localparam int STEP_UV = 5000;
  localparam int QUICK_RATE_MV_US = 10;
  localparam int QUICK_STEP_CYC = STEP_UV * 1000 / QUICK_RATE_MV_US / CLK_PERIOD_PS;
  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_RX = 2'b01,
    LK_EXEC = 2'b10,
    LK_TX = 2'b11
  } vid_link_t;
  typedef enum logic [1:0] {
    RM_QUICK = 2'b00,
    RM_GENTLE = 2'b01,
    RM_UNRAMP = 2'b10
  } vid_ramp_t;
endpackage : vid_pkg

// >>> verilog/vid_warn_cnt.sv
`timescale 1ns/10ps
module vid_warn_cnt
  import vid_pkg::*;
#(
  parameter int ACC_W = 20
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // control
  input wire logic tick_i,
  input wire logic above_i,
  input wire logic hold_i,
  input wire logic clr_i,
  // result
  output logic [7:0] cnt_o
);
  localparam logic [ACC_W-1:0] ACC_MAX = {ACC_W{1'b1}};
  logic [ACC_W-1:0] acc_r;

  // mantissa in high nibble, exponent in low nibble, pinned at ff
  function automatic logic [7:0] encode(input logic [ACC_W-1:0] v);
    logic [7:0] res;
    logic found;
    res = 8'hff;
    found = 1'b0;
    for (int e = 0; e < 16; e++)
    begin
      if (!found && ((v >> e) < 16))
      begin
        res = {4'((v >> e)), 4'(e)};
        found = 1'b1;
      end
    end
    return res;
  endfunction : encode

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      acc_r <= '0;
    else if (clr_i)
      acc_r <= '0;
    else if (tick_i && above_i && !hold_i && acc_r != ACC_MAX && encode(acc_r) != 8'hff)
      acc_r <= acc_r + 1'b1;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_o <= 8'h00;
    else
      cnt_o <= encode(acc_r);
  end
endmodule : vid_warn_cnt

// >>> verilog/vid_slave_regs.sv
`timescale 1ns/10ps
module vid_slave_regs
  import vid_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary value
  parameter logic [7:0] PRODUCT_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] SILICON_REV = 8'h01, // arbitrary value
  parameter logic [7:0] QUICK_RATE = 8'(QUICK_RATE_MV_US),
  parameter int QUICK_STEP = QUICK_STEP_CYC,
  parameter int TICK = TICK_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // serial link
  input wire logic sclk_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  output logic alert_o,
  output logic alert_oe_n_o,
  // regulator side
  input wire logic enable_i,
  input wire logic [7:0] boot_code_i,
  input wire logic [7:0] limit_strap_i,
  input wire logic [7:0] iout_adc_i,
  input wire logic [7:0] vout_adc_i,
  input wire logic [7:0] heat_adc_i,
  input wire logic [7:0] pout_adc_i,
  input wire logic [7:0] vin_adc_i,
  input wire logic [7:0] system_power_input_i,
  input wire logic over_target_i,
  input wire logic current_limit_i,
  input wire logic heat_flag_i,
  input wire logic deepest_power_state_i,
  output logic [7:0] vid_code_o,
  output logic hot_alarm_n_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] sclk_q;
  logic [1:0] sdio_q;
  logic [1:0] en_q;
  logic [1:0] ovr_q;
  logic [1:0] ilim_q;
  logic [1:0] heat_q;
  logic [1:0] deep_q;
  logic rise;
  logic fall;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sclk_q <= '0;
      sdio_q <= '1;
      en_q <= '0;
      ovr_q <= '0;
      ilim_q <= '0;
      heat_q <= '0;
      deep_q <= '0;
    end
    else
    begin
      sclk_q <= {sclk_q[1:0], sclk_i};
      sdio_q <= {sdio_q[0], sdio_i};
      en_q <= {en_q[0], enable_i};
      ovr_q <= {ovr_q[0], over_target_i};
      ilim_q <= {ilim_q[0], current_limit_i};
      heat_q <= {heat_q[0], heat_flag_i};
      deep_q <= {deep_q[0], deepest_power_state_i};
    end
  end
  assign rise = sclk_q[1] && !sclk_q[2];
  assign fall = !sclk_q[1] && sclk_q[2];

  // ----------------------------------------
  // link frame
  // ----------------------------------------
  vid_link_t st_r;
  logic [RX_BITS-1:0] rx_r;
  logic [4:0] bit_r;
  logic [TX_BITS-1:0] tx_r;
  logic exec;
  logic [4:0] cmd;
  logic [7:0] idx;
  logic [7:0] dat;
  logic par_bad;
  assign exec = (st_r == LK_EXEC);
  assign cmd = rx_r[21:17];
  assign idx = rx_r[16:9];
  assign dat = rx_r[8:1];
  assign par_bad = ^rx_r;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] target_r;
  logic [7:0] cur_r;
  vid_ramp_t mode_r;
  logic [7:0] ceil_r;
  logic [7:0] margin_r;
  logic [7:0] gdiv_r;
  logic [7:0] heatmax_r;
  logic [7:0] ccl_r;
  logic [7:0] multi_r;
  logic [7:0] wptr_r;
  logic [7:0] dbcclr_r;
  logic [7:0] crit_r;
  logic [7:0] w2lvl_r;
  logic [7:0] w1lvl_r;
  logic [7:0] dbcset_r;
  logic [7:0] limit_strap_r;
  logic [7:0] boot_r;
  logic booted_r;
  logic [3:0] stat1_r;
  logic [1:0] fault_r;
  logic [7:0] snap_r;
  logic [7:0] prevget_r;
  logic [7:0] w1cnt;
  logic [7:0] w2cnt;
  logic [7:0] rd;
  logic [1:0] ack;
  logic wr_ok;
  logic set_cmd;
  logic [7:0] grate;
  logic [4:0] gshift;
  always_comb
  begin
    case (gdiv_r)
      8'h01: gshift = 5'd1;
      8'h04: gshift = 5'd3;
      8'h08: gshift = 5'd4;
      default: gshift = 5'd2;
    endcase
    grate = QUICK_RATE >> gshift;
  end

  always_comb
  begin
    case (idx)
      IX_MAKER: rd = MAKER_CODE;
      IX_PRODUCT: rd = PRODUCT_CODE;
      IX_SIREV: rd = SILICON_REV;
      IX_PROTO: rd = PROTO_VAL;
      IX_FEATURE: rd = FEATURE_VAL;
      IX_STAT1: rd = {4'h0, stat1_r};
      IX_STAT2: rd = {6'h00, fault_r};
      IX_TZONE: rd = 8'h00;
      IX_PREVGET: rd = prevget_r;
      IX_IOUT: rd = iout_adc_i;
      IX_VOUT: rd = vout_adc_i;
      IX_HEAT: rd = heat_adc_i;
      IX_POUT: rd = pout_adc_i;
      IX_VIN: rd = vin_adc_i;
      IX_PIN: rd = 8'h00;
      IX_SNAP: rd = snap_r;
      IX_CCL: rd = ccl_r;
      IX_PLATLIM: rd = limit_strap_r;
      IX_HEATMAX: rd = heatmax_r;
      IX_QRATE: rd = QUICK_RATE;
      IX_GRATE: rd = grate;
      IX_BOOT: rd = boot_r;
      IX_GDIV: rd = gdiv_r;
      IX_DEEPLAT: rd = DEEPLAT_VAL;
      IX_LIGHTLAT: rd = LIGHTLAT_VAL;
      IX_RDYLAT: rd = RDYLAT_VAL;
      IX_CEIL: rd = ceil_r;
      IX_CURCODE: rd = target_r;
      IX_PSTATE: rd = 8'h00;
      IX_MARGIN: rd = margin_r;
      IX_MULTI: rd = multi_r;
      IX_WPTR: rd = wptr_r;
      IX_DBCCLR: rd = dbcclr_r;
      IX_CRIT: rd = crit_r;
      IX_W2LVL: rd = w2lvl_r;
      IX_W1LVL: rd = w1lvl_r;
      IX_W2CNT: rd = w2cnt;
      IX_W1CNT: rd = w1cnt;
      IX_DBCSET: rd = dbcset_r;
      default: rd = 8'h00;
    endcase
  end

  assign set_cmd = (cmd == CMD_QUICK) || (cmd == CMD_GENTLE) || (cmd == CMD_UNRAMP);
  always_comb
  begin
    wr_ok = 1'b0;
    case (idx)
      IX_CCL, IX_HEATMAX, IX_GDIV, IX_CEIL, IX_MARGIN, IX_MULTI, IX_WPTR,
      IX_DBCCLR, IX_CRIT, IX_W2LVL, IX_W1LVL, IX_DBCSET: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
    if (par_bad)
      ack = ACK_BAD;
    else if (set_cmd)
      ack = (dat > ceil_r || (cmd == CMD_UNRAMP && dat > target_r)) ? ACK_REJ : ACK_OK;
    else if (cmd == CMD_GET)
      ack = ACK_OK;
    else if (cmd == CMD_SETREG)
      ack = wr_ok ? ACK_OK : ACK_REJ;
    else
      ack = ACK_REJ;
  end

  // ----------------------------------------
  // link sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_r <= LK_IDLE;
      rx_r <= '0;
      bit_r <= '0;
      tx_r <= '0;
      sdio_o <= 1'b1;
      sdio_oe_n_o <= 1'b1;
    end
    else
    begin
      case (st_r)
        LK_IDLE:
          if (rise && !sdio_q[1])
          begin
            st_r <= LK_RX;
            bit_r <= '0;
          end
        LK_RX:
          if (rise)
          begin
            rx_r <= {rx_r[RX_BITS-2:0], sdio_q[1]};
            bit_r <= bit_r + 5'd1;
            if (bit_r == 5'(RX_BITS - 1))
              st_r <= LK_EXEC;
          end
        LK_EXEC:
        begin
          tx_r <= {ack, rd, ~^{ack, rd}};
          bit_r <= '0;
          st_r <= LK_TX;
        end
        LK_TX:
          if (fall)
          begin
            sdio_oe_n_o <= (bit_r == 5'(TX_BITS));
            sdio_o <= tx_r[TX_BITS-1];
            tx_r <= {tx_r[TX_BITS-2:0], 1'b1};
            bit_r <= bit_r + 5'd1;
            if (bit_r == 5'(TX_BITS))
            begin
              sdio_o <= 1'b1;
              st_r <= LK_IDLE;
            end
          end
        default: st_r <= LK_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // writable registers and captures
  // ----------------------------------------
  logic wr;
  assign wr = exec && !par_bad && cmd == CMD_SETREG;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ccl_r <= 8'h00;
      heatmax_r <= HEATMAX_RST;
      gdiv_r <= GDIV_RST;
      ceil_r <= CEIL_RST;
      margin_r <= 8'h00;
      multi_r <= 8'h00;
      wptr_r <= WPTR_RST;
      dbcclr_r <= 8'h00;
      crit_r <= 8'h00;
      w2lvl_r <= 8'h00;
      w1lvl_r <= 8'h00;
      dbcset_r <= 8'h00;
    end
    else if (wr)
    begin
      case (idx)
        IX_CCL: ccl_r <= dat;
        IX_HEATMAX: heatmax_r <= dat;
        IX_GDIV: gdiv_r <= dat;
        IX_CEIL: ceil_r <= dat;
        IX_MARGIN: margin_r <= dat;
        IX_MULTI: multi_r <= dat;
        IX_WPTR: wptr_r <= dat;
        IX_DBCCLR: dbcclr_r <= dat;
        IX_CRIT: crit_r <= dat;
        IX_W2LVL: w2lvl_r <= dat;
        IX_W1LVL: w1lvl_r <= dat;
        IX_DBCSET: dbcset_r <= dat;
        default: ccl_r <= ccl_r;
      endcase
    end
  end

  // straps are caught on the first edge after release, not under reset
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      booted_r <= 1'b0;
      limit_strap_r <= 8'h00;
      boot_r <= 8'h00;
    end
    else if (!booted_r)
    begin
      booted_r <= 1'b1;
      limit_strap_r <= limit_strap_i;
      boot_r <= boot_code_i;
    end
  end

  // status, faults, snapshot, last GET; hardware set beats read clear
  logic rd_stat1;
  logic [3:0] ev1;
  assign rd_stat1 = exec && !par_bad && cmd == CMD_GET && idx == IX_STAT1;
  assign ev1 = {ovr_q[1], ilim_q[1], heat_q[1], 1'b0};
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stat1_r <= 4'h0;
      fault_r <= 2'b00;
      snap_r <= 8'h00;
      prevget_r <= 8'h00;
      alert_o <= 1'b0;
      alert_oe_n_o <= 1'b1;
    end
    else
    begin
      stat1_r[3:1] <= (rd_stat1 ? 3'b000 : stat1_r[3:1]) | ev1[3:1];
      stat1_r[0] <= booted_r && en_q[1] && cur_r == target_r;
      if (exec)
        fault_r <= (cmd == CMD_GET && idx == IX_STAT2 && !par_bad ? 2'b00 : fault_r)
          | {!par_bad && !set_cmd && cmd != CMD_GET && cmd != CMD_SETREG, par_bad};
      if (exec && !par_bad && cmd == CMD_GET)
      begin
        prevget_r <= rd;
        if (idx == IX_STAT2)
          snap_r <= {6'h00, fault_r};
      end
      if ((ev1[3:1] & ~stat1_r[3:1]) != 3'b000 || (stat1_r[0] == 1'b0 && booted_r && cur_r == target_r && en_q[1]))
        alert_oe_n_o <= 1'b0;
      else if (rd_stat1)
        alert_oe_n_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // voltage ramp
  // ----------------------------------------
  logic [11:0] step_r;
  logic [11:0] period;
  logic step_hit;
  assign period = (mode_r == RM_GENTLE) ? 12'(QUICK_STEP << gshift) : 12'(QUICK_STEP);
  assign step_hit = (step_r >= period - 12'd1);
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      target_r <= 8'h00;
      cur_r <= 8'h00;
      mode_r <= RM_QUICK;
      step_r <= '0;
    end
    else if (!booted_r || !en_q[1])
    begin
      target_r <= booted_r ? boot_r : boot_code_i;
      cur_r <= 8'h00;
      mode_r <= RM_QUICK;
      step_r <= '0;
    end
    else
    begin
      if (exec && !par_bad && set_cmd && ack == ACK_OK)
      begin
        target_r <= dat;
        mode_r <= vid_ramp_t'(cmd[1:0] - 2'd1);
      end
      if (mode_r == RM_UNRAMP)
        cur_r <= target_r;
      else if (cur_r != target_r && step_hit)
        cur_r <= (cur_r < target_r) ? cur_r + 8'd1 : cur_r - 8'd1;
      step_r <= (step_hit || cur_r == target_r) ? '0 : step_r + 12'd1;
    end
  end

  // margin is a signed step count, clamped to the code range
  logic [9:0] sum;
  assign sum = {2'b00, cur_r} + {{2{margin_r[7]}}, margin_r};
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      vid_code_o <= 8'h00;
    else if (cur_r == 8'h00)
      vid_code_o <= 8'h00;
    else
      vid_code_o <= sum[9] ? 8'h00 : (sum[8] ? CODE_MAX : sum[7:0]);
  end

  // ----------------------------------------
  // system power monitor
  // ----------------------------------------
  logic [7:0] tick_r;
  logic tick;
  logic above;
  logic [19:0] deb_r;
  logic [19:0] limit;
  assign tick = (tick_r == 8'(TICK - 1));
  assign above = system_power_input_i > crit_r;
  assign limit = hot_alarm_n_o ? (20'(dbcset_r[7:4]) << dbcset_r[3:0]) : (20'(dbcclr_r[7:4]) << dbcclr_r[3:0]);
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tick_r <= 8'h00;
      deb_r <= '0;
      hot_alarm_n_o <= 1'b1;
    end
    else
    begin
      tick_r <= tick ? 8'h00 : tick_r + 8'd1;
      if (above == hot_alarm_n_o)
      begin
        if (deb_r >= limit)
        begin
          hot_alarm_n_o <= !above;
          deb_r <= '0;
        end
        else if (tick)
          deb_r <= deb_r + 20'd1;
      end
      else
        deb_r <= '0;
    end
  end

  logic clr1;
  logic clr2;
  assign clr1 = exec && !par_bad && ((cmd == CMD_GET && idx == IX_W1CNT) || (wr && idx == IX_W1LVL));
  assign clr2 = exec && !par_bad && ((cmd == CMD_GET && idx == IX_W2CNT) || (wr && idx == IX_W2LVL));
  vid_warn_cnt u_warn1 (
    .clk_i(clk_i), .resetn_i(resetn_i), .tick_i(tick), .above_i(system_power_input_i > w1lvl_r),
    .hold_i(deep_q[1]), .clr_i(clr1), .cnt_o(w1cnt)
  );
  vid_warn_cnt u_warn2 (
    .clk_i(clk_i), .resetn_i(resetn_i), .tick_i(tick), .above_i(system_power_input_i > w2lvl_r),
    .hold_i(deep_q[1]), .clr_i(clr2), .cnt_o(w2cnt)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_get(logic [7:0] ix);
    exec && !par_bad && cmd == CMD_GET && idx == ix;
  endsequence
  a_decay_up_refused: assert property (exec && cmd == CMD_UNRAMP && dat > target_r |-> ack != ACK_OK)
    else $error("upward unramped command accepted");
  a_ceiling_reject: assert property (exec && !par_bad && set_cmd && dat > ceil_r |=> tx_r[10:9] == ACK_REJ)
    else $error("code above ceiling not rejected");
  a_quick_gap: assert property (mode_r == RM_QUICK && en_q[1] && $changed(cur_r) && $past(en_q[1])
    |-> $past(step_r) == 12'(QUICK_STEP - 1))
    else $error("quick step spacing wrong");
  a_gentle_gap: assert property (mode_r == RM_GENTLE && $changed(cur_r) && $past(mode_r) == RM_GENTLE
    |-> $past(step_r) >= 12'(QUICK_STEP * 2 - 1))
    else $error("gentle step too fast");
  a_snapshot_copy: assert property (s_get(IX_STAT2) |=> snap_r == {6'h00, $past(fault_r)})
    else $error("snapshot not copied");
  a_get_recorded: assert property (s_get(IX_PROTO) |=> prevget_r == PROTO_VAL ##1 1'b1)
    else $error("last GET value lost");
  a_ro_write: assert property (wr && !wr_ok |=> $stable(ceil_r) && $stable(margin_r) && tx_r[10:9] == ACK_REJ)
    else $error("read-only write took effect");
  a_warn_clear: assert property (s_get(IX_W1CNT) |=> ##1 w1cnt == 8'h00)
    else $error("warning timer not cleared");
  a_hot_cause: assert property ($fell(hot_alarm_n_o) |-> $past(above))
    else $error("hot alarm without cause");
endmodule : vid_slave_regs

// >>> verification/vid_master_model.sv
`timescale 1ns/10ps
module vid_master_model (
  // link pins
  output logic sclk_o,
  output logic sdio_o,
  output logic sdio_en_o,
  input wire logic sdio_i
);
  initial
  begin
    sclk_o = 1'b0;
    sdio_o = 1'b1;
    sdio_en_o = 1'b0;
  end
  // clock stands low between frames; bad corrupts the parity on purpose
  task automatic frame(input logic [4:0] c, input logic [7:0] ix, input logic [7:0] d, input bit bad,
                       output logic [1:0] ack, output logic [7:0] q, output logic pe);
    logic [21:0] f;
    logic [10:0] r;
    f = {c, ix, d, (^{c, ix, d}) ^ bad};
    sdio_en_o = 1'b1;
    sdio_o = 1'b0;
    #80 sclk_o = 1'b1;
    for (int i = 21; i >= 0; i--)
    begin
      #80 sclk_o = 1'b0;
      sdio_o = f[i];
      #80 sclk_o = 1'b1;
    end
    for (int i = 10; i >= 0; i--)
    begin
      #80 sclk_o = 1'b0;
      sdio_en_o = 1'b0;
      #80 sclk_o = 1'b1;
      r[i] = sdio_i;
    end
    #80 sclk_o = 1'b0;
    #80;
    {ack, q} = r[10:1];
    pe = ~^r;
  endtask : frame
endmodule : vid_master_model

// >>> verification/vid_slave_regs_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; $display("FAIL %0t got %h", $time, a); end end
module vid_slave_regs_test;
  import vid_pkg::*;
  logic clk_i = 0;
  logic resetn_i = 0;
  logic en, ot, deep, al;
  logic sclk, m_sdio, m_en, sdio_o, sdio_oe_n, alert_oe_n, hot_n, pe;
  logic [7:0] boot, icc, adc, code, q, v;
  logic [7:0] spwr;
  logic [1:0] ack;
  int n_fail = 0;
  int num_checks = 0;
  int n;
  logic [7:0] ix_t[9] = '{IX_MAKER, IX_PRODUCT, IX_SIREV, IX_PROTO, IX_FEATURE, IX_HEATMAX, IX_GDIV, IX_GRATE, IX_CEIL};
  logic [7:0] ex_t[9] = '{8'h21, 8'h43, 8'h65, 8'h0e, 8'hd7, 8'h64, 8'h02, 8'h02, 8'hff};
  // pull-up wins when nobody drives
  wire sdio = !sdio_oe_n ? sdio_o : (m_en ? m_sdio : 1'b1);
  always #2.5 clk_i = ~clk_i;
  vid_master_model vid_master_model_inst (.sclk_o(sclk), .sdio_o(m_sdio), .sdio_en_o(m_en), .sdio_i(sdio));
  // identity codes are arbitrary
  vid_slave_regs #(.MAKER_CODE(8'h21), .PRODUCT_CODE(8'h43), .SILICON_REV(8'h65), .QUICK_STEP(16), .TICK(4))
  vid_slave_regs_inst (.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .sdio_i(sdio), .sdio_o(sdio_o),
    .sdio_oe_n_o(sdio_oe_n), .alert_o(al), .alert_oe_n_o(alert_oe_n), .enable_i(en), .boot_code_i(boot),
    .limit_strap_i(icc), .iout_adc_i(adc), .vout_adc_i(adc), .heat_adc_i(adc), .pout_adc_i(adc), .vin_adc_i(adc),
    .system_power_input_i(spwr), .over_target_i(ot), .current_limit_i(ot), .heat_flag_i(ot),
    .deepest_power_state_i(deep), .vid_code_o(code), .hot_alarm_n_o(hot_n));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmd(input logic [4:0] c, input logic [7:0] ix, input logic [7:0] d, input bit bad);
    vid_master_model_inst.frame(c, ix, d, bad, ack, q, pe);
    `CHK(pe, 1'b0)
    @(negedge clk_i);
  endtask : cmd
  // margin is a plain signed step count added to the code
  function automatic logic [7:0] margined(input logic [7:0] c, input logic [7:0] m);
    return c + m;
  endfunction : margined
  task automatic rd(input logic [7:0] ix, input logic [7:0] e);
    cmd(CMD_GET, ix, 8'h00, 0);
    `CHK(q, e)
  endtask : rd
  // cycles between two successive code steps
  task automatic gap();
    v = code;
    while (code === v) @(negedge clk_i);
    v = code;
    n = 0;
    while (code === v && n < 999)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask : gap
  task automatic settle(input logic [7:0] e);
    for (n = 0; code !== e && n < 4000; n++) @(negedge clk_i);
  endtask : settle
  task automatic results();
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    #400000;
    n_fail++;
    results();
  end
  initial
  begin
    void'($urandom(32'h6f78));
    en = 0;
    ot = 0;
    deep = 0;
    spwr = 8'h00;
    boot = 8'h40 + 8'($urandom_range(127));
    icc = $urandom;
    adc = $urandom;
    repeat (6) @(negedge clk_i);
    resetn_i = 1;
    repeat (4) @(negedge clk_i);
    icc = ~icc;
    rd(IX_PLATLIM, ~icc);
    foreach (ix_t[i]) rd(ix_t[i], ex_t[i]);
    rd(IX_PREVGET, 8'hff);
    rd(IX_IOUT, adc);
    rd(IX_VOUT, adc);
    rd(IX_HEAT, adc);
    cmd(CMD_SETREG, IX_PROTO, 8'h55, 0);
    `CHK(ack, ACK_REJ)
    rd(IX_PROTO, 8'h0e);
    cmd(CMD_SETREG, IX_HEATMAX, ~adc, 0);
    rd(IX_HEATMAX, ~adc);
    cmd(CMD_GET, IX_PROTO, 8'h00, 1);
    `CHK(ack, ACK_BAD)
    cmd(5'h1f, 8'h00, 8'h00, 0);
    `CHK(ack, ACK_REJ)
    rd(IX_STAT2, 8'h03);
    rd(IX_SNAP, 8'h03);
    en = 1;
    settle(boot);
    `CHK(code, boot)
    cmd(CMD_QUICK, 8'h00, boot + 8'h30, 0);
    gap();
    `CHK(n, 16)
    cmd(CMD_GENTLE, 8'h00, boot, 0);
    gap();
    `CHK(n, 64)
    settle(boot);
    cmd(CMD_UNRAMP, 8'h00, boot + 8'h01, 0);
    `CHK(ack, ACK_REJ)
    cmd(CMD_UNRAMP, 8'h00, boot - 8'h30, 0);
    `CHK(code, boot - 8'h30)
    cmd(CMD_SETREG, IX_MARGIN, 8'hfe, 0);
    `CHK(code, margined(boot - 8'h30, 8'hfe))
    cmd(CMD_SETREG, IX_CEIL, boot, 0);
    cmd(CMD_QUICK, 8'h00, boot + 8'h01, 0);
    `CHK(ack, ACK_REJ)
    cmd(CMD_UNRAMP, 8'h00, 8'h00, 0);
    `CHK(code, 8'h00)
    // settling already pulled the alert low; read it clear first so the event is seen
    cmd(CMD_GET, IX_STAT1, 8'h00, 0);
    `CHK(alert_oe_n, 1'b1)
    ot = 1;
    for (n = 0; alert_oe_n !== 1'b0 && n < 20; n++) @(negedge clk_i);
    `CHK(alert_oe_n, 1'b0)
    `CHK(al, 1'b0)
    ot = 0;
    cmd(CMD_GET, IX_STAT1, 8'h00, 0);
    `CHK(q[3:1], 3'b111)
    `CHK(alert_oe_n, 1'b1)
    cmd(CMD_SETREG, IX_CRIT, 8'h80, 0);
    cmd(CMD_SETREG, IX_W1LVL, 8'h40, 0);
    spwr = 8'hc0;
    repeat (8) @(negedge clk_i);
    `CHK(hot_n, 1'b0)
    spwr = 8'h00;
    repeat (8) @(negedge clk_i);
    `CHK(hot_n, 1'b1)
    cmd(CMD_SETREG, IX_DBCSET, 8'h12, 0);
    spwr = 8'hc0;
    repeat (8) @(negedge clk_i);
    `CHK(hot_n, 1'b1)
    repeat (24) @(negedge clk_i);
    `CHK(hot_n, 1'b0)
    cmd(CMD_GET, IX_W1CNT, 8'h00, 0);
    `CHK(q !== 8'h00, 1'b1)
    cmd(CMD_SETREG, IX_W1LVL, 8'hff, 0);
    rd(IX_W1CNT, 8'h00);
    deep = 1;
    cmd(CMD_SETREG, IX_W1LVL, 8'h40, 0);
    rd(IX_W1CNT, 8'h00);
    deep = 0;
    results();
  end
endmodule : vid_slave_regs_test
